// >>> core/vemtr_pkg.sv
package vemtr_pkg;
    // Register addresses on the serial bus
    localparam logic [7:0] ADDR_MODE_ONE = 8'h01;
    localparam logic [7:0] ADDR_MODE_TWO = 8'h02;
    localparam logic [7:0] ADDR_MODE_THREE = 8'h03;
    localparam logic [7:0] ADDR_MODE_FOUR = 8'h04;
    localparam logic [7:0] ADDR_TIMING_ZERO = 8'h07;
    localparam logic [7:0] ADDR_TIMING_ONE = 8'h08;
    // Reset values
    localparam logic [7:0] RST_MODE_ONE = 8'h58;
    localparam logic [7:0] RST_MODE_TWO = 8'h00;
    localparam logic [7:0] RST_MODE_THREE = 8'h00;
    localparam logic [7:0] RST_MODE_FOUR = 8'h10;
    localparam logic [7:0] RST_TIMING_ZERO = 8'h00;
    localparam logic [7:0] RST_TIMING_ONE = 8'h00;
    // Revision code, value arbitrary
    localparam logic [1:0] REVISION_CODE = 2'h1;
    // Mode one fields
    localparam int MR1_INTERLACE = 0;
    localparam int MR1_CC_LO = 1;
    localparam int MR1_DAC_C = 3;
    localparam int MR1_DAC_D = 4;
    localparam int MR1_DAC_B = 5;
    localparam int MR1_DAC_A = 6;
    localparam int MR1_COLOR_BAR = 7;
    // Mode two fields
    localparam int MR2_SQUARE = 0;
    localparam int MR2_GENLOCK_IN = 1;
    localparam int MR2_GENLOCK_TYPE = 2;
    localparam int MR2_LINE_LEN = 3;
    localparam int MR2_CHROMA = 4;
    localparam int MR2_BURST = 5;
    localparam int MR2_LOW_POWER = 6;
    // Mode three fields
    localparam int MR3_VBI_OPEN = 2;
    localparam int MR3_SCART = 3;
    localparam int MR3_CHROMA_SEL = 4;
    localparam int MR3_TTX_EN = 5;
    localparam int MR3_TTX_REQ_MODE = 6;
    localparam int MR3_DEFAULT_COLOR = 7;
    // Mode four fields
    localparam int MR4_OUT_SEL = 0;
    localparam int MR4_RGB_YUV = 1;
    localparam int MR4_RGB_SYNC = 2;
    localparam int MR4_LONG_VERTICAL_SYNC_OPTION = 3;
    localparam int MR4_PEDESTAL = 4;
    localparam int MR4_AV_FILTER = 5;
    localparam int MR4_SLEEP = 6;
    // Timing zero fields
    localparam int TR0_MASTER = 0;
    localparam int TR0_TMODE_LO = 1;
    localparam int TR0_BLANK = 3;
    localparam int TR0_LUMA_LO = 4;
    localparam int TR0_PIXEL16 = 6;
    localparam int TR0_CNT_RESET = 7;
    // Active pixel counts
    localparam logic [9:0] PIXELS_601 = 10'h2d0;
    localparam logic [9:0] PIXELS_470_NTSC = 10'h2c6;
    localparam logic [9:0] PIXELS_470_PAL = 10'h2be;
    // Luma delay step and its cycle count
    localparam int LUMA_STEP_NS = 74;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LUMA_STEP_CYC = LUMA_STEP_NS / CLK_PERIOD_NS;
    // Vsync length in half lines
    localparam logic [2:0] VSYNC_HALF_NTSC = 3'h6;
    localparam logic [2:0] VSYNC_HALF_PAL = 3'h5;
    localparam logic [2:0] VSYNC_HALF_SHORT = 3'h3;
    // DAC source codes
    typedef enum logic [2:0] {
        VEMTR_SRC_CVBS, VEMTR_SRC_Y, VEMTR_SRC_C, VEMTR_SRC_R,
        VEMTR_SRC_G, VEMTR_SRC_B, VEMTR_SRC_U, VEMTR_SRC_V
    } vemtr_src_t;
    // Timing counter reset sequence
    typedef enum logic [1:0] {
        VEMTR_TR_IDLE, VEMTR_TR_LOW, VEMTR_TR_HIGH
    } vemtr_trst_t;
endpackage

// >>> core/vemtr_regs.sv
// Functional notes
// - Interlace bit selects interlaced output; matters only in composite mode.
// - Two-bit field select puts closed captions on odd, even or both fields.
// - Each DAC powered individually; 0 on, 1 off; bits 3..6 are C,D,B,A.
// - Color bars output internal pattern and force master timing.
// - Square pixel only in slave mode; source supplies the matching clock.
// - Genlock input bit makes shared pin input; type picks reset or realtime.
// - Line length bit: 720 pixels, or 710 NTSC and 702 PAL.
// - Chroma and burst gated separately by two mode-two bits.
// - Low power bit reduces DAC current by 45 percent.
// - Two low bits of mode three read revision; writes do not alter.
// - VBI open passes VBI data; not in slave mode 0; blank wins.
// - Four select bits route DAC outputs; chroma select picks CVBS or chroma.
// - Teletext inserted only when enabled; request high or bitwise.
// - All-zero pixels show color code 00000000 or black per default bit.
// - Output select composite or RGB/YUV; YUV switch; sync on RGB.
// - Long vsync lasts 3 lines NTSC, 2.5 PAL; driven in master mode.
// - Pedestal bit adds NTSC pedestal; no effect in PAL.
// - Sleep keeps registers accessible; clearing or reset wakes.
// - Timing zero sets master, mode, blank use, luma delay, pixel width.
// - Low-high-low on counter reset bit resets timing counters.
// - Timing one sets hsync width, delays, vsync width, pixel adjust.
`timescale 1ns/1ps
`default_nettype none
module vemtr_regs
    import vemtr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic pal_mode,
    input wire logic subcarrier_reset_realtime_pin,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic interlace_out,
    output logic [1:0] cc_field_sel,
    output logic [3:0] dac_power_on,
    output logic color_bar_out,
    output logic master_out,
    output logic square_pixel_out,
    output logic subcarrier_reset_pulse,
    output logic realtime_control_out,
    output logic [9:0] active_pixels,
    output logic chroma_on,
    output logic burst_on,
    output logic low_power_out,
    output logic vbi_pass,
    output logic [2:0] dac_a_src,
    output logic [2:0] dac_b_src,
    output logic [2:0] dac_c_src,
    output logic [2:0] dac_d_src,
    output logic teletext_insert_en,
    output logic teletext_request_bitwise,
    output logic zero_pixel_black,
    output logic rgb_sync_out,
    output logic pedestal_on,
    output logic av_filter_out,
    output logic sleep_out,
    output logic [1:0] timing_mode,
    output logic blank_input_used,
    output logic [7:0] luma_delay_cycles,
    output logic pixel_port_16,
    output logic timing_counter_reset,
    output logic [2:0] vsync_half_lines,
    output logic [7:0] timing_adjust
);
    import vemtr_pkg::*;

    logic [7:0] mode_one_ff;
    logic [7:0] mode_two_ff;
    logic [7:0] mode_three_ff;
    logic [7:0] mode_four_ff;
    logic [7:0] timing_zero_ff;
    logic [7:0] timing_one_ff;
    logic pin_prev_ff;
    vemtr_trst_t trst_ff;
    logic rgb_mode;
    logic [7:0] nxt_rd_data;
    vemtr_src_t src_a;
    vemtr_src_t src_b;
    vemtr_src_t src_c;
    vemtr_src_t src_d;
    vemtr_src_t fourth_src;

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mode_one_ff <= RST_MODE_ONE;
            mode_two_ff <= RST_MODE_TWO;
            mode_three_ff <= RST_MODE_THREE;
            mode_four_ff <= RST_MODE_FOUR;
            timing_zero_ff <= RST_TIMING_ZERO;
            timing_one_ff <= RST_TIMING_ONE;
        end
        else if (wr_en)
        begin
            // Registers stay writable in sleep
            // no sleep gating
            if (reg_addr == ADDR_MODE_ONE)
                mode_one_ff <= wr_data;
            else if (reg_addr == ADDR_MODE_TWO)
                mode_two_ff <= wr_data;
            else if (reg_addr == ADDR_MODE_THREE)
                mode_three_ff <= {wr_data[7:2], 2'h0};
            else if (reg_addr == ADDR_MODE_FOUR)
                mode_four_ff <= wr_data;
            else if (reg_addr == ADDR_TIMING_ZERO)
                timing_zero_ff <= wr_data;
            else if (reg_addr == ADDR_TIMING_ONE)
                timing_one_ff <= wr_data;
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_comb
    begin
        // Unmapped addresses read zero
        nxt_rd_data = 8'h00;
        if (reg_addr == ADDR_MODE_ONE)
            nxt_rd_data = mode_one_ff;
        else if (reg_addr == ADDR_MODE_TWO)
            nxt_rd_data = mode_two_ff;
        else if (reg_addr == ADDR_MODE_THREE)
            nxt_rd_data = {mode_three_ff[7:2], REVISION_CODE};
        else if (reg_addr == ADDR_MODE_FOUR)
            nxt_rd_data = mode_four_ff;
        else if (reg_addr == ADDR_TIMING_ZERO)
            nxt_rd_data = timing_zero_ff;
        else if (reg_addr == ADDR_TIMING_ONE)
            nxt_rd_data = timing_one_ff;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= nxt_rd_data;
        end
    end

    // ************************************************************
    // DAC routing
    // ************************************************************
    always_comb
    begin
        rgb_mode = mode_four_ff[MR4_OUT_SEL];
        fourth_src = mode_three_ff[MR3_CHROMA_SEL] ? VEMTR_SRC_C : VEMTR_SRC_CVBS;
        src_c = VEMTR_SRC_C;
        src_b = VEMTR_SRC_CVBS;
        src_d = VEMTR_SRC_Y;
        src_a = fourth_src;
        if (rgb_mode)
        begin
            src_b = mode_four_ff[MR4_RGB_YUV] ? VEMTR_SRC_U : VEMTR_SRC_B;
            src_c = mode_four_ff[MR4_RGB_YUV] ? VEMTR_SRC_V : VEMTR_SRC_R;
            src_d = mode_four_ff[MR4_RGB_YUV] ? VEMTR_SRC_Y : VEMTR_SRC_G;
        end
        // scart swap of A and D
        if (mode_three_ff[MR3_SCART])
        begin
            src_a = src_d;
            src_d = fourth_src;
        end
    end

    // ************************************************************
    // Genlock pin
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_prev_ff <= 1'b0;
            subcarrier_reset_pulse <= 1'b0;
            realtime_control_out <= 1'b0;
        end
        else
        begin
            pin_prev_ff <= subcarrier_reset_realtime_pin;
            subcarrier_reset_pulse <= mode_two_ff[MR2_GENLOCK_IN] && !mode_two_ff[MR2_GENLOCK_TYPE]
                && subcarrier_reset_realtime_pin && !pin_prev_ff;
            realtime_control_out <= mode_two_ff[MR2_GENLOCK_IN] && mode_two_ff[MR2_GENLOCK_TYPE]
                && subcarrier_reset_realtime_pin;
        end
    end

    // ************************************************************
    // Timing counter reset sequence
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            trst_ff <= VEMTR_TR_IDLE;
            timing_counter_reset <= 1'b0;
        end
        else
        begin
            timing_counter_reset <= 1'b0;
            case (trst_ff)
                VEMTR_TR_IDLE:
                    if (!timing_zero_ff[TR0_CNT_RESET])
                        trst_ff <= VEMTR_TR_LOW;
                VEMTR_TR_LOW:
                    if (timing_zero_ff[TR0_CNT_RESET])
                        trst_ff <= VEMTR_TR_HIGH;
                VEMTR_TR_HIGH:
                    if (!timing_zero_ff[TR0_CNT_RESET])
                    begin
                        timing_counter_reset <= 1'b1;
                        trst_ff <= VEMTR_TR_LOW;
                    end
                default:
                    trst_ff <= VEMTR_TR_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Decoded controls
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            interlace_out <= 1'b0;
            cc_field_sel <= 2'h0;
            dac_power_on <= 4'h0;
            color_bar_out <= 1'b0;
            master_out <= 1'b0;
            square_pixel_out <= 1'b0;
            active_pixels <= PIXELS_601;
            chroma_on <= 1'b0;
            burst_on <= 1'b0;
            low_power_out <= 1'b0;
            rgb_sync_out <= 1'b0;
            pedestal_on <= 1'b0;
            av_filter_out <= 1'b0;
            sleep_out <= 1'b0;
        end
        else
        begin
            interlace_out <= mode_one_ff[MR1_INTERLACE] && !mode_four_ff[MR4_OUT_SEL];
            cc_field_sel <= mode_one_ff[MR1_CC_LO +: 2];
            dac_power_on <= ~{mode_one_ff[MR1_DAC_A], mode_one_ff[MR1_DAC_B],
                mode_one_ff[MR1_DAC_C], mode_one_ff[MR1_DAC_D]};
            color_bar_out <= mode_one_ff[MR1_COLOR_BAR];
            master_out <= timing_zero_ff[TR0_MASTER] || mode_one_ff[MR1_COLOR_BAR];
            square_pixel_out <= mode_two_ff[MR2_SQUARE] && !timing_zero_ff[TR0_MASTER]
                && !mode_one_ff[MR1_COLOR_BAR];
            if (!mode_two_ff[MR2_LINE_LEN])
                active_pixels <= PIXELS_601;
            else if (pal_mode)
                active_pixels <= PIXELS_470_PAL;
            else
                active_pixels <= PIXELS_470_NTSC;
            chroma_on <= mode_two_ff[MR2_CHROMA];
            burst_on <= mode_two_ff[MR2_BURST];
            low_power_out <= mode_two_ff[MR2_LOW_POWER];
            rgb_sync_out <= mode_four_ff[MR4_RGB_SYNC] && rgb_mode;
            pedestal_on <= mode_four_ff[MR4_PEDESTAL] && !pal_mode;
            av_filter_out <= mode_four_ff[MR4_AV_FILTER];
            sleep_out <= mode_four_ff[MR4_SLEEP];
        end
    end

    // Mode three controls
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            vbi_pass <= 1'b0;
            teletext_insert_en <= 1'b0;
            teletext_request_bitwise <= 1'b0;
            zero_pixel_black <= 1'b0;
        end
        else
        begin
            // blank wins, none in slave 0
            vbi_pass <= mode_three_ff[MR3_VBI_OPEN]
                && !(!timing_zero_ff[TR0_MASTER] && timing_zero_ff[TR0_TMODE_LO +: 2] == 2'h0)
                && !(timing_zero_ff[TR0_BLANK] && !timing_zero_ff[TR0_MASTER]);
            teletext_insert_en <= mode_three_ff[MR3_TTX_EN];
            teletext_request_bitwise <= mode_three_ff[MR3_TTX_REQ_MODE];
            zero_pixel_black <= mode_three_ff[MR3_DEFAULT_COLOR];
        end
    end

    // Routing registered so a select change never glitches a DAC
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dac_a_src <= 3'h0;
            dac_b_src <= 3'h0;
            dac_c_src <= 3'h0;
            dac_d_src <= 3'h0;
        end
        else
        begin
            dac_a_src <= src_a;
            dac_b_src <= src_b;
            dac_c_src <= src_c;
            dac_d_src <= src_d;
        end
    end

    // Timing controls
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            timing_mode <= 2'h0;
            blank_input_used <= 1'b0;
            luma_delay_cycles <= 8'h00;
            pixel_port_16 <= 1'b0;
            vsync_half_lines <= VSYNC_HALF_SHORT;
            timing_adjust <= 8'h00;
        end
        else
        begin
            timing_mode <= timing_zero_ff[TR0_TMODE_LO +: 2];
            blank_input_used <= timing_zero_ff[TR0_BLANK] && !timing_zero_ff[TR0_MASTER];
            luma_delay_cycles <= 8'(timing_zero_ff[TR0_LUMA_LO +: 2] * LUMA_STEP_CYC);
            pixel_port_16 <= timing_zero_ff[TR0_PIXEL16];
            if (!mode_four_ff[MR4_LONG_VERTICAL_SYNC_OPTION])
                vsync_half_lines <= VSYNC_HALF_SHORT;
            else if (pal_mode)
                vsync_half_lines <= VSYNC_HALF_PAL;
            else
                vsync_half_lines <= VSYNC_HALF_NTSC;
            timing_adjust <= timing_one_ff;
        end
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
    import vemtr_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic mclk, reset, pal_mode, subcarrier_reset_realtime_pin, wr_en, rd_en, rd_valid;
    logic [7:0] reg_addr, wr_data, rd_data, luma_delay_cycles, timing_adjust;
    logic interlace_out, color_bar_out, master_out, square_pixel_out, subcarrier_reset_pulse;
    logic realtime_control_out, chroma_on, burst_on, low_power_out, vbi_pass, teletext_insert_en;
    logic teletext_request_bitwise, zero_pixel_black, rgb_sync_out, pedestal_on, av_filter_out;
    logic sleep_out, blank_input_used, pixel_port_16, timing_counter_reset;
    logic [1:0] cc_field_sel, timing_mode;
    logic [3:0] dac_power_on;
    logic [9:0] active_pixels;
    logic [2:0] dac_a_src, dac_b_src, dac_c_src, dac_d_src, vsync_half_lines;
    int failures = 0;
    int samples_checked = 0;
    int cnt, at;
    logic [7:0] adr [8] = '{ADDR_MODE_ONE, ADDR_MODE_TWO, ADDR_MODE_THREE, ADDR_MODE_FOUR,
        ADDR_TIMING_ZERO, ADDR_TIMING_ONE, 8'h05, 8'h00};
    logic [7:0] rst_v [8] = '{RST_MODE_ONE, RST_MODE_TWO, {RST_MODE_THREE[7:2], REVISION_CODE},
        RST_MODE_FOUR, RST_TIMING_ZERO, RST_TIMING_ONE, 8'h00, 8'h00};
    // Packed {A,B,C,D} sources indexed by {chroma sel, out sel, yuv, swap}
    logic [11:0] route_v [16] = '{12'h011, 12'h210, 12'h011, 12'h210, 12'h15c, 12'h958, 12'h1b9, 12'h3b8,
        12'h411, 12'h212, 12'h411, 12'h212, 12'h55c, 12'h95a, 12'h5b9, 12'h3ba};
    vemtr_regs i_vemtr_regs (.*);
    vemtr_host i_vemtr_host (.*);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic close_out();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        i_vemtr_host.rd(a, d, ok);
        if (!ok)
        begin
            failures++;
            close_out();
        end
        else
            `CHK("read data", e, d)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_vemtr_host.wr(a, d);
    endtask
    task automatic apply(input logic [7:0] p);
        logic [7:0] e;
        for (int i = 0; i < 6; i++)
            wr(adr[i], p);
        settle();
        for (int i = 0; i < 6; i++)
        begin
            e = p;
            if (adr[i] == ADDR_MODE_TWO || adr[i] == ADDR_MODE_FOUR)
                e[7] = 1'b0;
            if (adr[i] == ADDR_MODE_THREE)
                e[1:0] = REVISION_CODE;
            rchk(adr[i], e);
        end
    endtask
    // Pulses are counted, not just seen, so a stuck pulse also fails
    task automatic watch(input bit sel, output int n, output int k0);
        n = 0;
        k0 = 0;
        for (int k = 1; k <= 6; k++)
        begin
            @(posedge mclk);
            #1;
            if ((sel ? timing_counter_reset : subcarrier_reset_pulse) === 1'b1)
            begin
                n++;
                k0 = k;
            end
        end
    endtask
    task automatic pin_edge(output int n);
        @(posedge mclk);
        subcarrier_reset_realtime_pin <= 1'b0;
        repeat (2) @(posedge mclk);
        subcarrier_reset_realtime_pin <= 1'b1;
        watch(1'b0, n, at);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        close_out();
    end
    initial
    begin
        reset = 1'b1;
        pal_mode = 1'b0;
        subcarrier_reset_realtime_pin = 1'b0;
        do_reset();
        for (int i = 0; i < 8; i++)
            rchk(adr[i], rst_v[i]);
        `CHK("dac power", 4'h4, dac_power_on)
        `CHK("pixels", PIXELS_601, active_pixels)
        apply(8'h7e);
        `CHK("cc field", 2'h3, cc_field_sel)
        `CHK("dac power", 4'h0, dac_power_on)
        `CHK("pixels", PIXELS_470_NTSC, active_pixels)
        `CHK("chroma burst", 2'h3, {chroma_on, burst_on})
        `CHK("low power", 1'b1, low_power_out)
        `CHK("vbi", 1'b0, vbi_pass)
        `CHK("teletext", 2'h3, {teletext_insert_en, teletext_request_bitwise})
        `CHK("default color", 1'b0, zero_pixel_black)
        `CHK("rgb sync", 1'b0, rgb_sync_out)
        `CHK("vsync", VSYNC_HALF_NTSC, vsync_half_lines)
        `CHK("pedestal", 1'b1, pedestal_on)
        `CHK("sleep", 1'b1, sleep_out)
        `CHK("timing", 4'hf, {timing_mode, blank_input_used, pixel_port_16})
        `CHK("luma", 3 * LUMA_STEP_CYC, luma_delay_cycles)
        `CHK("adjust", 8'h7e, timing_adjust)
        @(posedge mclk);
        pal_mode <= 1'b1;
        settle();
        `CHK("pixels", PIXELS_470_PAL, active_pixels)
        `CHK("vsync", VSYNC_HALF_PAL, vsync_half_lines)
        `CHK("pedestal", 1'b0, pedestal_on)
        apply(8'h01);
        `CHK("interlace", 1'b0, interlace_out)
        `CHK("dac power", 4'hf, dac_power_on)
        `CHK("sleep", 1'b0, sleep_out)
        `CHK("vsync", VSYNC_HALF_SHORT, vsync_half_lines)
        i_vemtr_host.tr_reset();
        watch(1'b1, cnt, at);
        `CHK("trst count", 1, cnt)
        `CHK("trst time", 1, at)
        wr(ADDR_MODE_ONE, 8'h80);
        settle();
        `CHK("bars", 2'h3, {color_bar_out, master_out})
        wr(ADDR_MODE_ONE, 8'h00);
        wr(ADDR_TIMING_ZERO, 8'h01);
        wr(ADDR_MODE_THREE, 8'h04);
        settle();
        `CHK("vbi", 1'b1, vbi_pass)
        wr(ADDR_TIMING_ZERO, 8'h00);
        settle();
        `CHK("vbi", 1'b0, vbi_pass)
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_MODE_THREE, {3'h0, i[3], i[0], 3'h0});
            wr(ADDR_MODE_FOUR, {6'h0, i[1], i[2]});
            settle();
            `CHK("routing", route_v[i], {dac_a_src, dac_b_src, dac_c_src, dac_d_src})
        end
        wr(ADDR_MODE_TWO, 8'h02);
        settle();
        pin_edge(cnt);
        `CHK("subcarrier", 1, cnt)
        `CHK("realtime", 1'b0, realtime_control_out)
        wr(ADDR_MODE_TWO, 8'h06);
        settle();
        pin_edge(cnt);
        `CHK("subcarrier", 0, cnt)
        `CHK("realtime", 1'b1, realtime_control_out)
        wr(ADDR_MODE_FOUR, 8'h05);
        wr(ADDR_MODE_ONE, 8'h01);
        wr(ADDR_MODE_TWO, 8'h01);
        settle();
        `CHK("interlace", 1'b0, interlace_out)
        `CHK("rgb sync", 1'b1, rgb_sync_out)
        `CHK("square", 1'b1, square_pixel_out)
        wr(ADDR_MODE_FOUR, 8'h04);
        wr(ADDR_TIMING_ZERO, 8'h01);
        settle();
        `CHK("interlace", 1'b1, interlace_out)
        `CHK("rgb sync", 1'b0, rgb_sync_out)
        `CHK("square", 1'b0, square_pixel_out)
        wr(ADDR_MODE_FOUR, 8'h40);
        settle();
        `CHK("sleep", 1'b1, sleep_out)
        do_reset();
        settle();
        `CHK("sleep", 1'b0, sleep_out)
        rchk(ADDR_MODE_FOUR, RST_MODE_FOUR);
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire

// >>> dv/vemtr_host.sv
`timescale 1ns/1ps
`default_nettype none
module vemtr_host
    import vemtr_pkg::*;
(
    input wire logic mclk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data
);
    // ****************************************
    // Host side register access
    // ****************************************
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = 8'hff;
        wr_data = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        reg_addr <= a;
        wr_data <= (a == ADDR_MODE_TWO || a == ADDR_MODE_FOUR) ? {1'b0, d[6:0]} : d;
        @(posedge mclk);
        wr_en <= 1'b0;
        reg_addr <= ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge mclk);
        rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        // Bounded wait so a silent device cannot hang the host
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(posedge mclk);
            ok = (rd_valid === 1'b1);
            d = rd_data;
        end
    endtask
    task automatic tr_reset();
        wr(ADDR_TIMING_ZERO, 8'h00);
        wr(ADDR_TIMING_ZERO, 8'h80);
        wr(ADDR_TIMING_ZERO, 8'h00);
    endtask
endmodule
`default_nettype wire

// >>> dv/vemtr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vemtr_regs_chk
    import vemtr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic pal_mode,
    input wire logic [7:0] rd_data,
    input wire logic [3:0] dac_power_on,
    input wire logic color_bar_out,
    input wire logic master_out,
    input wire logic chroma_on,
    input wire logic burst_on,
    input wire logic [9:0] active_pixels,
    input wire logic vbi_pass,
    input wire logic sleep_out,
    input wire logic [1:0] timing_mode,
    input wire logic blank_input_used,
    input wire logic [7:0] luma_delay_cycles,
    input wire logic timing_counter_reset
);
    // ****************************************
    // Read back, write to decoded output and output to output relations
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence s_wr(logic [7:0] a);
        wr_en && reg_addr == a;
    endsequence
    // Low write two edges back, the only legal cause of the pulse
    sequence s_trst_cause;
        $past(wr_en, 2) && $past(reg_addr, 2) == ADDR_TIMING_ZERO && !$past(wr_data[7], 2);
    endsequence
    revision_ro_a: assert property (rd_en && reg_addr == ADDR_MODE_THREE |=> rd_data[1:0] == REVISION_CODE)
        else $error("revision bits not read back");
    bars_master_a: assert property (color_bar_out |-> master_out)
        else $error("color bars without master timing");
    dac_power_a: assert property (s_wr(ADDR_MODE_ONE) |-> ##2 dac_power_on ==
        ~{$past(wr_data[6], 2), $past(wr_data[5], 2), $past(wr_data[3], 2), $past(wr_data[4], 2)})
        else $error("dac power does not follow mode one");
    chroma_gate_a: assert property (s_wr(ADDR_MODE_TWO) |-> ##2
        {chroma_on, burst_on} == {$past(wr_data[4], 2), $past(wr_data[5], 2)})
        else $error("chroma or burst gate wrong");
    line_length_a: assert property (s_wr(ADDR_MODE_TWO) |-> ##2 active_pixels ==
        (!$past(wr_data[3], 2) ? PIXELS_601 : (pal_mode ? PIXELS_470_PAL : PIXELS_470_NTSC)))
        else $error("active pixel count wrong");
    sleep_follow_a: assert property (s_wr(ADDR_MODE_FOUR) |-> ##2 sleep_out == $past(wr_data[6], 2))
        else $error("sleep does not follow mode four");
    trst_pulse_a: assert property (timing_counter_reset |-> s_trst_cause ##1 !timing_counter_reset)
        else $error("timing counter reset pulse without cause");
    // Effective master bit used, so bar forcing cannot raise a false alarm
    vbi_block_a: assert property (vbi_pass |-> (master_out || timing_mode != 2'h0)
        && !(blank_input_used && !master_out))
        else $error("vbi passed in slave mode 0 or under blank");
    luma_delay_a: assert property (s_wr(ADDR_TIMING_ZERO) |-> ##2
        luma_delay_cycles == $past(wr_data[5:4], 2) * LUMA_STEP_CYC)
        else $error("luma delay count wrong");
endmodule
bind vemtr_regs vemtr_regs_chk i_vemtr_regs_chk (.mclk, .reset, .wr_en, .rd_en, .reg_addr, .wr_data,
    .pal_mode, .rd_data, .dac_power_on, .color_bar_out, .master_out, .chroma_on, .burst_on, .active_pixels,
    .vbi_pass, .sleep_out, .timing_mode, .blank_input_used, .luma_delay_cycles, .timing_counter_reset);
`default_nettype wire
